// ---- dv/ssa_i2c_master.sv ----
`timescale 1ns/10ps
module ssa_i2c_master (
    input  wire logic scl,       // serial clock wire level
    input  wire logic sda,       // serial data wire level
    output logic      scl_pull,  // high pulls the clock low
    output logic      sda_pull   // high pulls the data low
);
    initial
    begin
        scl_pull = 1'b0;
        sda_pull = 1'b0;
    end

    // the slave may stretch, so wait for the wire itself, bounded
    task automatic release_scl();
        scl_pull = 1'b0;
        for (int k = 0; k < 4000 && !scl; k++)
            #25;
    endtask

    // long low phase so a stretch lands before the master lets go
    task automatic bit_io(input logic b, output logic s);
        #50 sda_pull = !b;
        #100 release_scl();
        #40 s = sda;
        #10 scl_pull = 1'b1;
    endtask

    task automatic start();
        sda_pull = 1'b1;
        #100 scl_pull = 1'b1;
    endtask

    task automatic stop();
        #50 sda_pull = 1'b1;
        #100 release_scl();
        #100 sda_pull = 1'b0;
        #200;
    endtask

    task automatic put_byte(input logic [7:0] v, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--)
            bit_io(v[i], s);
        bit_io(1'b1, s);
        ack = !s;
    endtask

    task automatic get_byte(input logic ack, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--)
        begin
            bit_io(1'b1, s);
            d[i] = s;
        end
        bit_io(!ack, s);
    endtask
endmodule

// ---- dv/ssa_monitor.sv ----
`timescale 1ns/10ps
module ssa_monitor #(
    parameter int BUF_DEPTH = 2
) (
    input wire logic                           CLK,      // system clock
    input wire logic                           RST_B,    // synchronous reset, active low
    input wire logic [ssa_pkg::REG_ADDR_W-1:0] ADDR,     // register offset
    input wire logic [ssa_pkg::DATA_W-1:0]     WDATA,    // register write data
    input wire logic                           WR,       // write strobe
    input wire logic                           RD,       // read strobe
    input wire logic [ssa_pkg::DATA_W-1:0]     RDATA,    // read data
    input wire logic                           SCL_I,    // serial clock level
    input wire logic                           SCL_O,    // serial clock drive value
    input wire logic                           SCL_OE,   // serial clock pulled low
    input wire logic                           SDA_I,    // serial data level
    input wire logic                           SDA_O,    // serial data drive value
    input wire logic                           SDA_OE,   // serial data pulled low
    input wire logic                           TX_READY  // transmit buffer has room
);
    import ssa_pkg::*;

    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RST_B);

    a_rdata_idle: assert property (!$past(RD) |-> RDATA == 8'h00)
        else $error("read data not zero outside a read answer cycle");
    a_open_drain: assert property (SCL_O == 1'b0 && SDA_O == 1'b0)
        else $error("open drain drive value not low");
    a_master_flag_low: assert property (RD && ADDR == OFS_CTRL
        |=> !RDATA[CTRL_MASTER])
        else $error("master flag set in a slave only block");
    a_unmapped_read: assert property (RD && ADDR > OFS_CFG |=> RDATA == 8'h00)
        else $error("unmapped offset read not zero");
    a_stretch_with_si: assert property (RD && ADDR == OFS_CTRL ##1
        RDATA[CTRL_SI] && !RDATA[CTRL_STOP] |-> $past(SCL_OE))
        else $error("serial clock not held while event pending");
    a_sda_change_low: assert property ($changed(SDA_OE) |-> !SCL_I)
        else $error("data line changed while clock high");
    a_stretch_starts_low: assert property ($rose(SCL_OE) |-> !SCL_I)
        else $error("clock stretch started while clock high");
    a_sda_phase_hold: assert property ($rose(SDA_OE) |-> SDA_OE [*4])
        else $error("data low drive shorter than a clock phase");
endmodule

bind ssa_top ssa_monitor #(.BUF_DEPTH(BUF_DEPTH)) u_monitor (
    .CLK(CLK), .RST_B(RST_B), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
    .RDATA(RDATA), .SCL_I(SCL_I), .SCL_O(SCL_O), .SCL_OE(SCL_OE), .SDA_I(SDA_I),
    .SDA_O(SDA_O), .SDA_OE(SDA_OE), .TX_READY(TX_READY)
);

// ---- dv/ssa_tb_top.sv ----
`timescale 1ns/10ps
module ssa_tb_top;
    import ssa_pkg::*;

    logic       clk = 1'b0;
    logic       rst_b = 1'b0;
    logic [2:0] addr = 3'h0;
    logic [7:0] wdata = 8'h00;
    logic       wr_s = 1'b0;
    logic       rd_s = 1'b0;
    logic [7:0] rdata;
    logic       scl_o, scl_oe, sda_o, sda_oe, tx_ready, m_scl, m_sda;
    int         fails = 0;
    int         n_compared = 0;
    // pull-ups on both wires: a released line reads high
    wire logic  scl_w = !(m_scl || (scl_oe && !scl_o));
    wire logic  sda_w = !(m_sda || (sda_oe && !sda_o));
    logic [6:0] own [8] = '{7'h34, 7'h34, 7'h34, 7'h34, 7'h34, 7'h70, 7'h70, 7'h34};
    logic [6:0] msk [8] = '{7'h7f, 7'h7f, 7'h7f, 7'h7e, 7'h7e, 7'h73, 7'h73, 7'h7f};
    logic [6:0] adr [8] = '{7'h34, 7'h35, 7'h00, 7'h35, 7'h36, 7'h7c, 7'h71, 7'h00};
    logic [7:0] gcs = 8'b0000_0100;
    logic [7:0] hits = 8'b0010_1101;

    always #12.5 clk = ~clk;

    ssa_top dut (
        .CLK(clk), .RST_B(rst_b), .ADDR(addr), .WDATA(wdata), .WR(wr_s), .RD(rd_s),
        .RDATA(rdata), .SCL_I(scl_w), .SCL_O(scl_o), .SCL_OE(scl_oe), .SDA_I(sda_w),
        .SDA_O(sda_o), .SDA_OE(sda_oe), .TX_READY(tx_ready)
    );
    ssa_i2c_master u_master (.scl(scl_w), .sda(sda_w), .scl_pull(m_scl), .sda_pull(m_sda));

    task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
        n_compared++;
        if (s !== e)
        begin
            fails++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask

    task automatic end_sim();
        if (fails == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // bus tasks start and end just after a rising edge
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        wr_s <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr_s <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        rd_s <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd_s <= 1'b0;
        #1 d = rdata;
    endtask

    task automatic wait_si(output logic [7:0] c);
        for (int k = 0; k < 3000; k++)
        begin
            rd(OFS_CTRL, c);
            if (c[CTRL_SI])
                break;
        end
        chk("si_raised", c & 8'h01, 8'h01);
    endtask

    // one read transfer: firmware side and bus master run side by side
    task automatic xact(input logic [6:0] a, input logic exp, input logic sw);
        logic [7:0] c [4];
        logic [7:0] e, d0, d1, b0;
        logic       ack;
        b0 = {1'b1, a};
        if (exp)
        begin
            wr(OFS_DATA, b0);
            wr(OFS_DATA, 8'h3c);
            wr(OFS_DATA, 8'hc3);
            rd(OFS_CFG, e);
            chk("cfg_full", e & 8'h06, 8'h04);
            chk("tx_ready_full", {7'h0, tx_ready}, 8'h00);
        end
        fork
            begin
                u_master.start();
                u_master.put_byte({a, 1'b1}, ack);
                if (ack)
                begin
                    u_master.get_byte(1'b1, d0);
                    u_master.get_byte(1'b0, d1);
                end
                u_master.stop();
            end
            if (exp || sw)
            begin
                for (int k = 0; k < (exp ? 4 : 1); k++)
                begin
                    wait_si(c[k]);
                    if (k == 2)
                    begin
                        wr(OFS_DATA, 8'h99);
                        rd(OFS_CTRL, e);
                    end
                    wr(OFS_CTRL, {6'h0, exp, 1'b0});
                end
            end
        join
        chk("addr_ack", {7'h0, ack}, {7'h0, exp});
        if (sw)
            chk("ack_request", c[0] & 8'h09, 8'h09);
        if (exp && !sw)
            chk("addr_status", c[0] & 8'hf9, 8'h61);
        if (exp)
        begin
            chk("byte0", d0, b0);
            chk("byte1", d1, 8'h3c);
            chk("acked_status", c[1] & 8'hf3, 8'h43);
            chk("nacked_status", c[2] & 8'hf3, 8'h41);
            chk("late_write_err", e & 8'h04, 8'h04);
            chk("stop_status", c[3] & 8'hf1, 8'h11);
        end
        rd(OFS_CTRL, e);
        chk("no_pending_si", e & 8'h01, 8'h00);
        chk("tx_ready_idle", {7'h0, tx_ready}, 8'h01);
    endtask

    // write transfer: hardware acknowledges the data byte as well
    task automatic t_write();
        logic [7:0] c, d;
        logic       a0, a1;
        fork
            begin
                u_master.start();
                u_master.put_byte({7'h34, 1'b0}, a0);
                u_master.put_byte(8'h5a, a1);
                u_master.stop();
            end
            for (int k = 0; k < 3; k++)
            begin
                wait_si(c);
                if (k == 1)
                    rd(OFS_DATA, d);
                wr(OFS_CTRL, 8'h02);
            end
        join
        chk("wr_addr_ack", {7'h0, a0}, 8'h01);
        chk("wr_data_ack", {7'h0, a1}, 8'h01);
        chk("rx_data", d, 8'h5a);
        chk("wr_stop", c & 8'hf1, 8'h11);
    endtask

    task automatic t_reset();
        logic [7:0] v;
        logic [7:0] ev [7] = '{8'h00, 8'h00, ADDR_RST, MASK_RST, 8'h02, 8'h00, 8'h00};
        wr(3'h6, 8'hff);
        for (int i = 0; i < 7; i++)
        begin
            rd(i[2:0], v);
            chk("reset_value", v, ev[i]);
        end
    endtask

    task automatic t_match();
        for (int i = 0; i < 8; i++)
        begin
            wr(OFS_ADDR, {own[i], gcs[i]});
            wr(OFS_MASK, {msk[i], 1'b1});
            xact(adr[i], hits[i], 1'b0);
        end
    endtask

    // hardware acknowledge off: firmware decides, even for a foreign address
    task automatic t_swack();
        wr(OFS_MASK, {7'h7f, 1'b0});
        xact(7'h12, 1'b1, 1'b1);
        xact(7'h34, 1'b0, 1'b1);
    endtask

    task automatic t_inhibit();
        wr(OFS_MASK, {7'h7f, 1'b1});
        wr(OFS_ADDR, {7'h34, 1'b0});
        wr(OFS_CFG, 8'h01);
        xact(7'h34, 1'b0, 1'b0);
        wr(OFS_CFG, 8'h00);
        xact(7'h34, 1'b1, 1'b0);
    endtask

    initial
    begin
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        #1;
        t_reset();
        t_match();
        t_swack();
        t_inhibit();
        t_write();
        end_sim();
    end

    // thirteen transfers need well under ten thousand cycles
    initial
    begin
        #1500000;
        fails++;
        end_sim();
    end
endmodule

// ---- shared/ssa_buf_if.sv ----
`timescale 1ns/10ps
interface ssa_buf_if #(parameter int W = 8) ();
    logic           in_valid;
    logic           in_ready;
    logic [W-1:0]   in_data;
    logic           out_valid;
    logic           out_ready;
    logic [W-1:0]   out_data;
    logic           flush;

    modport ctrl (
        output in_valid, in_data, out_ready, flush,
        input  in_ready, out_valid, out_data
    );
    modport store (
        input  in_valid, in_data, out_ready, flush,
        output in_ready, out_valid, out_data
    );
endinterface

// ---- shared/ssa_pkg.sv ----
package ssa_pkg;

    localparam int          DATA_W      = 8;
    localparam int          REG_ADDR_W  = 3;
    localparam int          TXBUF_DEPTH = 2;
    localparam logic [3:0]  BYTE_BITS   = 4'h8;
    localparam logic [6:0]  GC_ADDR     = 7'h00;

    // register offsets
    localparam logic [2:0]  OFS_CTRL    = 3'h0;   // smb_control_reg
    localparam logic [2:0]  OFS_DATA    = 3'h1;   // smb_data_reg
    localparam logic [2:0]  OFS_ADDR    = 3'h2;   // slave_addr_reg
    localparam logic [2:0]  OFS_MASK    = 3'h3;   // slave_mask_reg
    localparam logic [2:0]  OFS_CFG     = 3'h4;   // slave config and buffer status

    // smb_control_reg fields
    localparam int          CTRL_SI     = 0;
    localparam int          CTRL_ACK    = 1;
    localparam int          CTRL_ERR    = 2;
    localparam int          CTRL_ACK_REQUEST_FLAG  = 3;
    localparam int          CTRL_STOP   = 4;
    localparam int          CTRL_START  = 5;
    localparam int          CTRL_TXDIR  = 6;
    localparam int          CTRL_MASTER = 7;

    // address, mask and config fields
    localparam int          ADDR_GC     = 0;
    localparam int          MASK_HWACK  = 0;
    localparam int          CFG_INH     = 0;
    localparam int          CFG_TXRDY   = 1;
    localparam int          CFG_TXVLD   = 2;

    // reset values
    localparam logic [7:0]  ADDR_RST    = 8'h00;
    localparam logic [7:0]  MASK_RST    = 8'hfe;
    localparam logic [7:0]  CFG_RST     = 8'h00;

    typedef enum logic [3:0] {
        SSA_IDLE,
        SSA_IGNORE,
        SSA_ADDR,
        SSA_ACK,
        SSA_RX_BIT,
        SSA_TX_LOAD,
        SSA_TX_BIT,
        SSA_TX_ACK,
        SSA_WAIT_STOP
    } ssa_state_t;

endpackage

// ---- src/ssa_buf.sv ----
`timescale 1ns/10ps
module ssa_buf #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 2
) (
    input  wire logic   CLK,    // system clock
    input  wire logic   RST_B,  // synchronous reset, active low
    ssa_buf_if.store    bus     // fill and drain sides
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PW-1:0]               wp;
        logic [PW-1:0]               rp;
        logic [CW-1:0]               cnt;
    } ssa_buf_st_t;

    ssa_buf_st_t r;
    ssa_buf_st_t n;
    logic        push;
    logic        pop;

    function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
        ptr_inc = (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
    endfunction

    assign bus.in_ready  = (r.cnt != CW'(DEPTH));
    assign bus.out_valid = (r.cnt != '0);
    assign bus.out_data  = r.mem[r.rp];
    assign push          = bus.in_valid && bus.in_ready;
    assign pop           = bus.out_valid && bus.out_ready;

    always_comb
    begin
        n = r;
        if (bus.flush)
        begin
            n.wp  = '0;
            n.rp  = '0;
            n.cnt = '0;
        end
        else
        begin
            if (push)
            begin
                n.mem[r.wp] = bus.in_data;
                n.wp        = ptr_inc(r.wp);
            end
            if (pop)
            begin
                n.rp = ptr_inc(r.rp);
            end
            if (push && !pop)
            begin
                n.cnt = r.cnt + CW'(1);
            end
            else if (pop && !push)
            begin
                n.cnt = r.cnt - CW'(1);
            end
        end
    end

    always_ff @(posedge CLK)
    begin
        if (!RST_B)
        begin
            r <= '0;
        end
        else
        begin
            r <= n;
        end
    end
endmodule

// ---- src/ssa_top.sv ----
`timescale 1ns/10ps
module ssa_top #(
    parameter int BUF_DEPTH = ssa_pkg::TXBUF_DEPTH
) (
    input  wire logic                          CLK,     // system clock, 40 MHz
    input  wire logic                          RST_B,   // synchronous reset, active low
    input  wire logic [ssa_pkg::REG_ADDR_W-1:0] ADDR,   // register offset
    input  wire logic [ssa_pkg::DATA_W-1:0]    WDATA,   // register write data
    input  wire logic                          WR,      // write strobe
    input  wire logic                          RD,      // read strobe
    output logic      [ssa_pkg::DATA_W-1:0]    RDATA,   // read data, cycle after RD
    input  wire logic                          SCL_I,   // serial clock line level
    output logic                               SCL_O,   // serial clock drive value
    output logic                               SCL_OE,  // serial clock pulled low
    input  wire logic                          SDA_I,   // serial data line level
    output logic                               SDA_O,   // serial data drive value
    output logic                               SDA_OE,  // serial data pulled low
    output logic                               TX_READY // transmit buffer has room
);
    import ssa_pkg::*;

    typedef struct packed {
        ssa_state_t  state;
        logic [7:0]  shreg;
        logic [3:0]  cnt;
        logic        addr_phase;
        logic        rw;
        logic        acked;
        logic        scl_s1;
        logic        scl_s2;
        logic        scl_d;
        logic        sda_s1;
        logic        sda_s2;
        logic        sda_d;
        logic        scl_oe;
        logic        sda_oe;
        logic        scl_o;
        logic        sda_o;
        logic        si;
        logic        ack_req;
        logic        ack;
        logic        start_f;
        logic        stop_f;
        logic        tx_dir;
        logic        err;
        logic        nack_seen;
        logic [6:0]  own;
        logic        gc_en;
        logic [6:0]  mask;
        logic        hw_ack;
        logic        inhibit;
        logic [7:0]  rx_data;
        logic [7:0]  rdata;
        logic        tx_ready;
    } ssa_top_st_t;

    ssa_top_st_t r;
    ssa_top_st_t n;

    logic        scl_rise;
    logic        scl_fall;
    logic        start_det;
    logic        stop_det;
    logic        si_clr;
    logic        push;
    logic        pop;
    logic        flush;
    logic        addressed;
    logic        byte_done;

    ssa_buf_if #(.W(DATA_W)) bif ();

    ssa_buf #(
        .WIDTH (DATA_W),
        .DEPTH (BUF_DEPTH)
    ) u_buf (
        .CLK   (CLK),
        .RST_B (RST_B),
        .bus   (bif)
    );

    assign bif.in_valid  = push;
    assign bif.in_data   = WDATA;
    assign bif.out_ready = pop;
    assign bif.flush     = flush;

    // only second and delayed stages are looked at, never the first stage
    assign scl_rise  = r.scl_s2 && !r.scl_d;
    assign scl_fall  = !r.scl_s2 && r.scl_d;
    assign start_det = r.scl_s2 && r.scl_d && r.sda_d && !r.sda_s2;
    assign stop_det  = r.scl_s2 && r.scl_d && !r.sda_d && r.sda_s2;
    assign byte_done = scl_fall && (r.cnt == BYTE_BITS);

    assign addressed = (r.state == SSA_ACK && r.acked) || (r.state == SSA_TX_LOAD)
                    || (r.state == SSA_TX_BIT) || (r.state == SSA_TX_ACK)
                    || (r.state == SSA_RX_BIT) || (r.state == SSA_WAIT_STOP);

    function automatic logic addr_hit(input logic [6:0] rx,
                                      input logic [6:0] own,
                                      input logic [6:0] mask,
                                      input logic       gc);
        addr_hit = (((rx ^ own) & mask) == 7'h00)
                || (gc && (rx == GC_ADDR));
    endfunction

    always_comb
    begin
        n        = r;
        push     = 1'b0;
        pop      = 1'b0;
        flush    = 1'b0;
        si_clr   = 1'b0;
        n.scl_s1 = SCL_I;
        n.scl_s2 = r.scl_s1;
        n.scl_d  = r.scl_s2;
        n.sda_s1 = SDA_I;
        n.sda_s2 = r.sda_s1;
        n.sda_d  = r.sda_s2;
        n.scl_o  = 1'b0;
        n.sda_o  = 1'b0;
        n.rdata  = 8'h00;
        n.tx_ready = bif.in_ready;

        if (WR)
        begin
            case (ADDR)
                OFS_CTRL:
                begin
                    si_clr = !WDATA[CTRL_SI];
                    n.ack  = WDATA[CTRL_ACK];
                    if (!WDATA[CTRL_ERR])
                    begin
                        n.err = 1'b0;
                    end
                end
                OFS_DATA:
                begin
                    // loading after a NACK, before the flag is serviced, is a fault
                    if (r.nack_seen && r.si)
                    begin
                        n.err = 1'b1;
                    end
                    else
                    begin
                        push = 1'b1;
                    end
                end
                OFS_ADDR:
                begin
                    n.own   = WDATA[7:1];
                    n.gc_en = WDATA[ADDR_GC];
                end
                OFS_MASK:
                begin
                    n.mask   = WDATA[7:1];
                    n.hw_ack = WDATA[MASK_HWACK];
                end
                OFS_CFG:
                begin
                    n.inhibit = WDATA[CFG_INH];
                end
                default:
                begin
                end
            endcase
        end

        if (si_clr)
        begin
            n.si      = 1'b0;
            n.start_f = 1'b0;
            n.stop_f  = 1'b0;
            if (r.ack_req)
            begin
                // firmware answers the pending byte with the ack it writes now
                n.ack_req = 1'b0;
                n.acked   = WDATA[CTRL_ACK];
            end
        end

        if (RD)
        begin
            case (ADDR)
                OFS_CTRL: n.rdata = {1'b0, r.tx_dir, r.start_f, r.stop_f,
                                     r.ack_req, r.err, r.ack, r.si};
                OFS_DATA: n.rdata = r.rx_data;
                OFS_ADDR: n.rdata = {r.own, r.gc_en};
                OFS_MASK: n.rdata = {r.mask, r.hw_ack};
                OFS_CFG:  n.rdata = {5'h00, bif.out_valid, bif.in_ready, r.inhibit};
                default:  n.rdata = 8'h00;
            endcase
        end

        unique case (r.state)
            SSA_IDLE, SSA_IGNORE, SSA_WAIT_STOP:
            begin
            end
            SSA_ADDR, SSA_RX_BIT:
            begin
                if (scl_rise)
                begin
                    n.shreg = {r.shreg[6:0], r.sda_s2};
                    n.cnt   = r.cnt + 4'h1;
                end
                else if (byte_done)
                begin
                    n.cnt        = 4'h0;
                    n.addr_phase = (r.state == SSA_ADDR);
                    if (r.state == SSA_ADDR)
                    begin
                        n.rw = r.shreg[0];
                    end
                    else
                    begin
                        n.rx_data = r.shreg;
                    end
                    if ((r.state == SSA_ADDR) && (r.inhibit
                        || (r.hw_ack && !addr_hit(r.shreg[7:1], r.own,
                                                  r.mask, r.gc_en))))
                    begin
                        // unmatched address or inhibit set: no ACK and silence until START
                        n.state = SSA_IGNORE;
                    end
                    else if (r.hw_ack)
                    begin
                        n.state  = SSA_ACK;
                        n.acked  = 1'b1;
                        n.sda_oe = 1'b1;
                    end
                    else
                    begin
                        n.state   = SSA_ACK;
                        n.acked   = 1'b0;
                        n.si      = 1'b1;
                        n.ack_req = 1'b1;
                    end
                end
            end
            SSA_ACK:
            begin
                n.sda_oe = n.acked && !n.ack_req;
                if (scl_fall)
                begin
                    n.sda_oe = 1'b0;
                    if (!r.acked)
                    begin
                        n.state = SSA_IGNORE;
                    end
                    else
                    begin
                        if (r.hw_ack)
                        begin
                            n.si = 1'b1;
                        end
                        if (r.addr_phase && r.rw)
                        begin
                            n.state  = SSA_TX_LOAD;
                            n.tx_dir = 1'b1;
                        end
                        else
                        begin
                            n.state = SSA_RX_BIT;
                        end
                    end
                end
            end
            SSA_TX_LOAD:
            begin
                // clock stays stretched until firmware has cleared SI and left a byte in the buffer
                if (!r.si && bif.out_valid)
                begin
                    pop      = 1'b1;
                    n.shreg  = bif.out_data;
                    n.sda_oe = !bif.out_data[7];
                    n.cnt    = 4'h0;
                    n.state  = SSA_TX_BIT;
                end
            end
            SSA_TX_BIT:
            begin
                if (scl_fall)
                begin
                    if (r.cnt == BYTE_BITS - 4'h1)
                    begin
                        n.sda_oe = 1'b0;
                        n.state  = SSA_TX_ACK;
                    end
                    else
                    begin
                        n.shreg  = {r.shreg[6:0], 1'b0};
                        n.sda_oe = !r.shreg[6];
                        n.cnt    = r.cnt + 4'h1;
                    end
                end
            end
            SSA_TX_ACK:
            begin
                if (scl_rise)
                begin
                    n.ack = !r.sda_s2;
                end
                if (scl_fall)
                begin
                    n.si = 1'b1;
                    if (r.ack)
                    begin
                        n.state = SSA_TX_LOAD;
                    end
                    else
                    begin
                        n.nack_seen = 1'b1;
                        n.state     = SSA_WAIT_STOP;
                    end
                end
            end
        endcase

        if (start_det)
        begin
            n.state     = SSA_ADDR;
            n.cnt       = 4'h0;
            n.sda_oe    = 1'b0;
            n.start_f   = 1'b1;
            n.tx_dir    = 1'b0;
            n.nack_seen = 1'b0;
            n.ack_req   = 1'b0;
        end
        else if (stop_det)
        begin
            if (addressed)
            begin
                n.stop_f = 1'b1;
                n.si     = 1'b1;
            end
            // stale bytes must not leak into the next read
            flush       = 1'b1;
            n.state     = SSA_IDLE;
            n.sda_oe    = 1'b0;
            n.tx_dir    = 1'b0;
            n.nack_seen = 1'b0;
            n.ack_req   = 1'b0;
        end

        // extra cycle of hold after a load or a firmware ack decision gives the data bit
        // setup before release, so sda never moves while scl is high
        n.scl_oe = (n.si && (n.state != SSA_IDLE))
                || (n.state == SSA_TX_LOAD) || (r.state == SSA_TX_LOAD)
                || ((r.state == SSA_ACK) && r.ack_req);
    end

    always_ff @(posedge CLK)
    begin
        if (!RST_B)
        begin
            r         <= '0;
            r.state   <= SSA_IDLE;
            r.scl_s1  <= 1'b1;
            r.scl_s2  <= 1'b1;
            r.scl_d   <= 1'b1;
            r.sda_s1  <= 1'b1;
            r.sda_s2  <= 1'b1;
            r.sda_d   <= 1'b1;
            r.own     <= ADDR_RST[7:1];
            r.gc_en   <= ADDR_RST[ADDR_GC];
            r.mask    <= MASK_RST[7:1];
            r.hw_ack  <= MASK_RST[MASK_HWACK];
            r.inhibit <= CFG_RST[CFG_INH];
        end
        else
        begin
            r <= n;
        end
    end

    assign RDATA    = r.rdata;
    assign SCL_O    = r.scl_o;
    assign SCL_OE   = r.scl_oe;
    assign SDA_O    = r.sda_o;
    assign SDA_OE   = r.sda_oe;
    assign TX_READY = r.tx_ready;
endmodule
